/* File: verilog/cpu_cycle_unit.sv */
// Purpose: Instruction cycle timing, status register, zero page address and program counter bytes.
// Assumes: Each instruction has a tabulated count of at least one cycle.
// Notes: The T flag is sampled when an instruction is taken, so a flag change lands on the next one.
`timescale 1ns/1ps
module cpu_cycle_unit (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Instruction request
	input wire logic instStart,
	input wire cpu_cycle_pkg::instDesc_t instDesc,
	output logic instReady,
	output logic instDone,
	// Program counter byte loads
	input wire logic pcLoadHigh,
	input wire logic pcLoadLow,
	input wire logic [7:0] pcByteIn,
	// State outputs
	output cpu_cycle_pkg::pcBytes_t pcBytes,
	output logic [7:0] procStatusReg,
	output logic [7:0] addressLowByte,
	output logic [7:0] addressHighByte,
	output logic [cpu_cycle_pkg::CYC_W-1:0] lastCycles
);
	import cpu_cycle_pkg::*;

	// ----------------------------------------
	// Cycle extension decode
	// ----------------------------------------
	function automatic logic [CYC_W-1:0] extraCycles(input instDesc_t d, input logic tFlag);
		logic [CYC_W-1:0] e;
		e = EXTRA_NONE;
		if (tFlag) begin
			case (d.note)
				NOTE_ONE: e = EXTRA_NOTE_ONE;
				NOTE_TWO: e = EXTRA_NOTE_TWO;
				NOTE_THREE: e = EXTRA_NOTE_THREE;
				default: e = EXTRA_NONE;
			endcase
		end
		if (d.isBranch && d.branchTaken) begin
			e = e + EXTRA_BRANCH;
		end
		return e;
	endfunction : extraCycles

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} state_t;

	state_t state_q, state_d;
	logic [CYC_W-1:0] cnt_q, cnt_d;
	logic [CYC_W-1:0] total_q, total_d;
	instDesc_t desc_q, desc_d;
	logic [7:0] flags_q, flags_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] addr_q, addr_d;
	logic take;
	logic [CYC_W-1:0] totalNow;

	assign instReady = (state_q == ST_IDLE);
	assign take = instStart && instReady;
	assign instDone = (state_q == ST_EXEC) && (cnt_q == EXTRA_NONE);
	assign totalNow = CYC_W'(instDesc.baseCycles) + extraCycles(instDesc, flags_q[FLAG_T]);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		total_d = total_q;
		desc_d = desc_q;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					desc_d = instDesc;
					total_d = totalNow;
					cnt_d = totalNow - CYC_ONE;
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (cnt_q == EXTRA_NONE) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q - CYC_ONE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cnt_q <= EXTRA_NONE;
			total_q <= EXTRA_NONE;
			desc_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			total_q <= total_d;
			desc_q <= desc_d;
		end
	end

	// ----------------------------------------
	// Status, address and program counter
	// ----------------------------------------
	// In decimal mode the N, V and Z values are stored as delivered; software must not trust them.
	always_comb begin
		flags_d = flags_q;
		addr_d = addr_q;
		pc_d = pc_q;
		if (instDone) begin
			flags_d = (flags_q & ~desc_q.flagMask) | (desc_q.flagVals & desc_q.flagMask);
		end
		if (take && instDesc.zeroPageMode) begin
			addr_d = {ZERO_PAGE_HIGH, instDesc.operand};
		end
		if (pcLoadHigh) begin
			pc_d[15:8] = pcByteIn;
		end
		if (pcLoadLow) begin
			pc_d[7:0] = pcByteIn;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags_q <= STATUS_RESET;
			addr_q <= {ZERO_PAGE_HIGH, ZERO_PAGE_HIGH};
			pc_q <= PC_RESET;
		end else begin
			flags_q <= flags_d;
			addr_q <= addr_d;
			pc_q <= pc_d;
		end
	end

	assign procStatusReg = flags_q;
	assign addressLowByte = addr_q[7:0];
	assign addressHighByte = addr_q[15:8];
	assign pcBytes = {pc_q[15:8], pc_q[7:0]};
	assign lastCycles = total_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_note_one_extra: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.note == NOTE_ONE && flags_q[FLAG_T] && !instDesc.isBranch
		|=> total_q == CYC_W'($past(instDesc.baseCycles)) + 5'h03)
		else $error("Note one instruction lacks three extra cycles.");

	a_note_two_extra: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.note == NOTE_TWO && flags_q[FLAG_T] && !instDesc.isBranch
		|=> total_q == CYC_W'($past(instDesc.baseCycles)) + 5'h02)
		else $error("Note two instruction lacks two extra cycles.");

	a_note_three_extra: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.note == NOTE_THREE && flags_q[FLAG_T] && !instDesc.isBranch
		|=> total_q == CYC_W'($past(instDesc.baseCycles)) + 5'h01)
		else $error("Note three instruction lacks one extra cycle.");

	a_no_t_plain: assert property (@(posedge core_clk) disable iff (rst)
		take && !flags_q[FLAG_T] && !(instDesc.isBranch && instDesc.branchTaken)
		|=> total_q == CYC_W'($past(instDesc.baseCycles)))
		else $error("Cycles extended with T flag clear.");

	a_branch_taken: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.isBranch && instDesc.branchTaken && instDesc.note == NOTE_NONE
		&& instDesc.baseCycles == 4'h2
		|=> !instDone ##1 !instDone ##1 !instDone ##1 instDone)
		else $error("Taken branch does not last four cycles.");

	a_branch_untaken: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.isBranch && !instDesc.branchTaken && instDesc.note == NOTE_NONE
		&& instDesc.baseCycles == 4'h2
		|=> !instDone ##1 instDone)
		else $error("Untaken branch does not last two cycles.");

	a_flags_unnamed: assert property (@(posedge core_clk) disable iff (rst)
		instDone |=> (flags_q & ~$past(desc_q.flagMask)) == ($past(flags_q) & ~$past(desc_q.flagMask)))
		else $error("Unaffected flag changed.");

	a_flags_named: assert property (@(posedge core_clk) disable iff (rst)
		instDone |=> (flags_q & $past(desc_q.flagMask)) == ($past(desc_q.flagVals) & $past(desc_q.flagMask)))
		else $error("Affected flag not written.");

	a_zero_page_addr: assert property (@(posedge core_clk) disable iff (rst)
		take && instDesc.zeroPageMode
		|=> addressHighByte == 8'h00 && addressLowByte == $past(instDesc.operand))
		else $error("Zero page address wrongly formed.");

	a_pc_bytes: assert property (@(posedge core_clk) disable iff (rst)
		pcLoadLow && !pcLoadHigh |=> pcBytes.pcLowByte == $past(pcByteIn) && $stable(pcBytes.pcHighByte))
		else $error("Program counter low byte load failed.");

	a_pc_high_load: assert property (@(posedge core_clk) disable iff (rst)
		pcLoadHigh && !pcLoadLow |=> pcBytes.pcHighByte == $past(pcByteIn) && $stable(pcBytes.pcLowByte))
		else $error("Program counter high byte load failed.");

	// A request offered while busy must leave the latched total untouched.
	a_busy_refused: assert property (@(posedge core_clk) disable iff (rst)
		instStart && !instReady |=> $stable(lastCycles))
		else $error("Request taken while busy.");

	a_done_single: assert property (@(posedge core_clk) disable iff (rst)
		instDone |=> !instDone)
		else $error("Completion lasts more than one cycle.");

	a_flags_hold: assert property (@(posedge core_clk) disable iff (rst)
		!instDone |=> $stable(procStatusReg))
		else $error("Status changed outside completion.");

	a_addr_hold: assert property (@(posedge core_clk) disable iff (rst)
		!(take && instDesc.zeroPageMode) |=> $stable(addressLowByte) && $stable(addressHighByte))
		else $error("Address changed without zero page request.");

endmodule : cpu_cycle_unit

/* File: verilog/cpu_cycle_pkg.sv */
// Purpose: Shared constants and types for the cycle and status flag unit.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// - Cycle note one: add three cycles while the X-modified arithmetic flag is set.
// - Cycle note two: add two cycles while the X-modified arithmetic flag is set.
// - Cycle note three: add one cycle while the X-modified arithmetic flag is set.
// - Taken branch adds two cycles; untaken branch keeps the tabulated count.
// - In decimal mode arithmetic negative, overflow and zero flags are meaningless.
// - Status bits seven to zero: N, V, T, B, D, I, Z, C.
// - Zero page address: operand is low byte, high byte forced to zero.
// - Program counter is sixteen bits, handled as high and low bytes.
package cpu_cycle_pkg;

	// ----------------------------------------
	// Widths and timing
	// ----------------------------------------
	localparam int BASE_W = 4;
	localparam int CYC_W = 5;
	localparam logic [CYC_W-1:0] EXTRA_NOTE_ONE = 5'h03;
	localparam logic [CYC_W-1:0] EXTRA_NOTE_TWO = 5'h02;
	localparam logic [CYC_W-1:0] EXTRA_NOTE_THREE = 5'h01;
	localparam logic [CYC_W-1:0] EXTRA_BRANCH = 5'h02;
	localparam logic [CYC_W-1:0] EXTRA_NONE = 5'h00;
	localparam logic [CYC_W-1:0] CYC_ONE = 5'h01;

	// ----------------------------------------
	// Status register layout
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_I = 2;
	localparam int FLAG_D = 3;
	localparam int FLAG_B = 4;
	localparam int FLAG_T = 5;
	localparam int FLAG_V = 6;
	localparam int FLAG_N = 7;
	localparam logic [7:0] STATUS_RESET = 8'h04;
	localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		NOTE_NONE = 2'h0,
		NOTE_ONE = 2'h1,
		NOTE_TWO = 2'h2,
		NOTE_THREE = 2'h3
	} cycNote_t;

	typedef struct packed {
		logic [BASE_W-1:0] baseCycles;
		cycNote_t note;
		logic isBranch;
		logic branchTaken;
		logic zeroPageMode;
		logic [7:0] operand;
		logic [7:0] flagMask;
		logic [7:0] flagVals;
	} instDesc_t;

	typedef struct packed {
		logic [7:0] pcHighByte;
		logic [7:0] pcLowByte;
	} pcBytes_t;

endpackage : cpu_cycle_pkg

/* File: verif/cpu_cycle_unit_tb.sv */
// Purpose: Self-checking bench for the cycle timing and status flag unit.
// Assumes: Inputs change at the falling edge; one request at a time.
// Notes: A queue pairs each taken instruction with the completion that answers it.
`timescale 1ns/1ps
module tb;
	import cpu_cycle_pkg::*;
	typedef struct packed {
		logic [CYC_W-1:0] total;
		logic [7:0] adLo;
		logic [7:0] adHi;
		logic [7:0] flags;
		logic [31:0] takeCnt;
	} expNote_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic instStart = 1'b0;
	instDesc_t instDesc = '0;
	logic pcLoadHigh = 1'b0;
	logic pcLoadLow = 1'b0;
	logic [7:0] pcByteIn = 8'h00;
	logic instReady;
	logic instDone;
	pcBytes_t pcBytes;
	logic [7:0] procStatusReg;
	logic [7:0] addressLowByte;
	logic [7:0] addressHighByte;
	logic [CYC_W-1:0] lastCycles;
	int errors = 0;
	int comparisons = 0;
	int seed = 32'h62cf;
	logic [31:0] cnt = 0;
	logic [7:0] flagModel = STATUS_RESET;
	logic [7:0] adLo = 8'h00;
	logic [7:0] adHi = 8'h00;
	logic [15:0] pcModel = PC_RESET;
	expNote_t scoreboard[$];
	expNote_t e;
	instDesc_t d;

	cpu_cycle_unit i_dut (.core_clk(core_clk), .rst(rst), .instStart(instStart), .instDesc(instDesc),
		.instReady(instReady), .instDone(instDone), .pcLoadHigh(pcLoadHigh), .pcLoadLow(pcLoadLow),
		.pcByteIn(pcByteIn), .pcBytes(pcBytes), .procStatusReg(procStatusReg),
		.addressLowByte(addressLowByte), .addressHighByte(addressHighByte), .lastCycles(lastCycles));

	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) cnt <= cnt + 1;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	// The flag sampled for the extra cycles is the one standing when the request is taken.
	task automatic run_inst(input instDesc_t di);
		logic [CYC_W-1:0] extra;
		int i;
		i = 0;
		do begin
			@(negedge core_clk);
			i++;
		end while (instReady !== 1'b1 && i < 40);
		check(32'(instReady), 32'h1);
		extra = EXTRA_NONE;
		if (flagModel[FLAG_T]) begin
			case (di.note)
				NOTE_ONE: extra = EXTRA_NOTE_ONE;
				NOTE_TWO: extra = EXTRA_NOTE_TWO;
				NOTE_THREE: extra = EXTRA_NOTE_THREE;
				default: extra = EXTRA_NONE;
			endcase
		end
		if (di.isBranch && di.branchTaken) extra = extra + EXTRA_BRANCH;
		if (di.zeroPageMode) begin
			adLo = di.operand;
			adHi = ZERO_PAGE_HIGH;
		end
		flagModel = (flagModel & ~di.flagMask) | (di.flagVals & di.flagMask);
		scoreboard.push_back(expNote_t'{{1'b0, di.baseCycles} + extra, adLo, adHi, flagModel, cnt + 1});
		instStart = 1'b1;
		instDesc = di;
		@(negedge core_clk);
		// A request while busy must be dropped, so a junk one is offered here.
		instDesc = instDesc_t'(33'({$random(seed), $random(seed)}));
		@(negedge core_clk);
		instStart = 1'b0;
	endtask : run_inst

	always @(negedge core_clk) begin
		if (instDone === 1'b1 && rst === 1'b0) begin
			check(32'(scoreboard.size() > 0), 32'h1);
			e = scoreboard.pop_front();
			check(32'(lastCycles), 32'(e.total));
			check(cnt - e.takeCnt, 32'(e.total) - 1);
			check(32'({addressHighByte, addressLowByte}), 32'({e.adHi, e.adLo}));
			@(negedge core_clk);
			check(32'(procStatusReg), 32'(e.flags));
		end
	end

	initial begin
		#40000;
		check(32'h0, 32'h1);
		final_report();
	end

	initial begin
		repeat (12) @(negedge core_clk);
		check(32'(procStatusReg), 32'(STATUS_RESET));
		check(32'({instReady, instDone, lastCycles}), 32'h40);
		check(32'(pcBytes), 32'(PC_RESET));
		rst = 1'b0;
		for (int n = 0; n < 80; n++) begin
			d = instDesc_t'(33'({$random(seed), $random(seed)}));
			if (d.baseCycles == 4'h0) d.baseCycles = 4'h1;
			run_inst(d);
		end
		// Two-cycle branches, taken and not, so the branch timing checks are reached.
		d = '0;
		d.baseCycles = 4'h2;
		d.isBranch = 1'b1;
		for (int b = 0; b < 2; b++) begin
			d.branchTaken = b[0];
			run_inst(d);
		end
		for (int k = 1; k < 4; k++) begin
			pcByteIn = 8'($random(seed));
			{pcLoadHigh, pcLoadLow} = 2'(k);
			if (k[1]) pcModel[15:8] = pcByteIn;
			if (k[0]) pcModel[7:0] = pcByteIn;
			@(negedge core_clk);
			check(32'({pcBytes.pcHighByte, pcBytes.pcLowByte}), 32'(pcModel));
		end
		pcLoadHigh = 1'b0;
		pcLoadLow = 1'b0;
		repeat (30) @(negedge core_clk);
		check(32'(scoreboard.size()), 32'h0);
		final_report();
	end
endmodule : tb
